// ===== include/sae_pkg.sv
/*
  Package for the serial audio port with its second control register:
  register offsets, field positions, carrier structs and framing codes.
  Assumes a 32-bit word-wide register port with byte offsets on word boundaries.
*/
package sae_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFS_CTL_ONE     = 8'h00;
  localparam logic [7:0]  OFS_CTL_TWO     = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_MASK        = 8'h0C;
  localparam logic [7:0]  OFS_TX_DATA     = 8'h10;
  localparam logic [7:0]  OFS_RX_DATA     = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTL1_ON_BIT     = 15;
  localparam int          C2_SIGN_EXT     = 15;
  localparam int          C2_FRM_ERR_EN   = 12;
  localparam int          C2_OVF_EN       = 11;
  localparam int          C2_UDR_EN       = 10;
  localparam int          C2_IGN_OVF      = 9;
  localparam int          C2_IGN_UDR      = 8;
  localparam int          C2_AUD_EN       = 7;
  localparam int          C2_MONO         = 3;
  localparam int          C2_PROTO_LSB    = 0;
  localparam int          ST_EVT_LSB      = 0;
  localparam int          ST_RX_FULL      = 8;
  localparam int          ST_TX_FULL      = 9;
  localparam int          ST_HALTED       = 10;
  localparam int          EVT_W           = 3;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Framing codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  PROTO_I2S       = 2'h0;
  localparam logic [1:0]  PROTO_LEFT_J    = 2'h1;
  localparam logic [1:0]  PROTO_RIGHT_J   = 2'h2;
  localparam logic [1:0]  PROTO_PCM       = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rx_sign_extend;
    logic       frame_error_event_en;
    logic       rx_overflow_event_en;
    logic       tx_underrun_event_en;
    logic       ignore_rx_overflow;
    logic       ignore_tx_underrun;
    logic       audio_protocol_en;
    logic       audio_mono_format;
    logic [1:0] audio_protocol_select;
  } sae_ctl2_t;

  localparam sae_ctl2_t CTL2_RESET = '0;

  typedef struct packed {
    logic tx_underrun_flag;
    logic rx_overflow_flag;
    logic frame_error_flag;
  } sae_evt_t;

  typedef struct packed {
    logic bclk;
    logic frame;
    logic sdi;
  } sae_link_in_t;

endpackage

// ===== hdl/sae_sync_edge.sv
/*
  Two-flop synchroniser with edge detection for a group of slow pins.
  Assumes the pins change far slower than the sampling clock.
*/
`timescale 1ns/100ps
module sae_sync_edge #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // Pins and results
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // ----------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
  assign o_fall  = ~sync_q & prev_q;

endmodule // sae_sync_edge

// ===== hdl/sae_audio_port.sv
/*
  Serial audio / plain serial slave port with its second control register,
  sticky error events, mask and one error interrupt.
  Assumes the partner drives bit clock and frame (word select or chip select,
  low active) far slower than i_ref_clk; one-word transmit and receive holding registers.
*/
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps

module sae_audio_port
  import sae_pkg::*;
#(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rstn,
  // Register port
  input  wire logic [sae_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sae_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [sae_pkg::DATA_W-1:0]  o_rdata,
  // Serial link
  input  wire sae_pkg::sae_link_in_t       i_link,
  output logic                             o_sdo,
  // Interrupt
  output logic                             o_err_irq
);
  import sae_pkg::*;

  localparam int                CW      = $clog2(WORD_W + 1);
  localparam logic [CW-1:0]     CNT_END = CW'(WORD_W);
  localparam logic [CW-1:0]     CNT_ONE = CW'(1);

  // Refuse widths the shift engine cannot hold
  if (WORD_W < 2 || WORD_W > DATA_W)
  begin : g_bad_width
    $error("WORD_W must lie between 2 and 32");
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  sae_link_in_t lvl;
  sae_link_in_t rise;
  sae_link_in_t fall;

  sae_sync_edge #(.W(3)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_link),
    .o_level   (lvl),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                on_q;
  sae_ctl2_t           ctl2_q;
  sae_evt_t            status_q;
  sae_evt_t            mask_q;
  logic                halted_q;
  logic [WORD_W-1:0]   tx_buf_q;
  logic                tx_full_q;
  logic [WORD_W-1:0]   rx_buf_q;
  logic                rx_full_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                irq_q;

  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_stat;
  logic wr_mask;
  logic wr_tx;
  logic rd_rx;

  assign wr_ctl1 = i_wr && (i_addr == OFS_CTL_ONE);
  assign wr_ctl2 = i_wr && (i_addr == OFS_CTL_TWO);
  assign wr_stat = i_wr && (i_addr == OFS_STATUS);
  assign wr_mask = i_wr && (i_addr == OFS_MASK);
  assign wr_tx   = i_wr && (i_addr == OFS_TX_DATA);
  assign rd_rx   = i_rd && (i_addr == OFS_RX_DATA);

  // Effective audio settings
  logic       aud;
  logic       mono;
  logic [1:0] proto;
  assign aud   = ctl2_q.audio_protocol_en;
  assign mono  = aud && ctl2_q.audio_mono_format;
  assign proto = aud ? ctl2_q.audio_protocol_select : PROTO_I2S;

  // ----------------------------------------------------------------
  // Serial engine decode
  // ----------------------------------------------------------------
  logic              active;
  logic              slot_q;
  logic              chan_q;
  logic              skip_q;
  logic [CW-1:0]     cnt_q;
  logic [WORD_W-1:0] rx_sh_q;
  logic [WORD_W-1:0] tx_sh_q;
  logic [WORD_W-1:0] mono_word_q;
  logic              sdo_q;

  logic              frame_start;
  logic              frame_end;
  logic              word_done;
  logic              auto_start;
  logic              start_now;
  logic              start_chan;
  logic              start_delay;
  logic              mid_word;
  logic              frm_err;
  logic              ovf;
  logic              udr;
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] load_word;
  logic              take_tx;

  assign active   = on_q && !halted_q;
  assign mid_word = slot_q && (cnt_q != '0) && (cnt_q != CNT_END);

  always_comb
  begin
    frame_start = 1'b0;
    frame_end   = 1'b0;
    start_chan  = 1'b0;
    start_delay = 1'b0;
    if (!aud)
    begin
      frame_start = fall.frame;
      frame_end   = rise.frame;
    end
    else if (proto == PROTO_PCM)
    begin
      frame_start = rise.frame;
      start_delay = 1'b1;
    end
    else
    begin
      // Slot width equals word width, so right-justified aligns like left
      frame_start = rise.frame || fall.frame;
      start_chan  = (proto == PROTO_I2S) ? lvl.frame : !lvl.frame;
      start_delay = (proto == PROTO_I2S);
    end
  end

  assign word_done  = active && slot_q && rise.bclk && !skip_q && (cnt_q == CNT_END - CNT_ONE);
  // Plain mode repeats words while selected; PCM follows left with right
  assign auto_start = word_done && (aud ? ((proto == PROTO_PCM) && !chan_q) : !lvl.frame);
  assign start_now  = active && (frame_start || auto_start);
  assign frm_err    = active && (frame_start || frame_end) && mid_word;
  assign rx_word    = {rx_sh_q[WORD_W-2:0], lvl.sdi};
  assign ovf        = word_done && rx_full_q && !rd_rx;

  logic next_chan;
  assign next_chan = auto_start ? aud : start_chan;

  always_comb
  begin
    take_tx   = 1'b0;
    udr       = 1'b0;
    load_word = '0;
    if (start_now)
    begin
      if (mono && next_chan)
        load_word = mono_word_q;
      else if (tx_full_q)
      begin
        load_word = tx_buf_q;
        take_tx   = 1'b1;
      end
      else
        udr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      slot_q  <= 1'b0;
      chan_q  <= 1'b0;
      skip_q  <= 1'b0;
      cnt_q   <= '0;
      rx_sh_q <= '0;
    end
    else if (!active || (!aud && frame_end))
    begin
      slot_q <= 1'b0;
      cnt_q  <= '0;
      skip_q <= 1'b0;
    end
    else if (start_now)
    begin
      slot_q <= 1'b1;
      chan_q <= next_chan;
      skip_q <= start_delay && !auto_start;
      cnt_q  <= '0;
    end
    else if (slot_q && rise.bclk)
    begin
      if (skip_q)
        skip_q <= 1'b0;
      else if (cnt_q != CNT_END)
      begin
        rx_sh_q <= rx_word;
        cnt_q   <= cnt_q + CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_sh_q     <= '0;
      sdo_q       <= 1'b0;
      mono_word_q <= '0;
    end
    else if (!active)
    begin
      sdo_q   <= 1'b0;
      tx_sh_q <= '0;
    end
    else if (start_now)
    begin
      if (!next_chan)
        mono_word_q <= load_word;
      // Delayed framings put the first bit out on the next falling edge
      if (skip_q || (start_delay && !auto_start))
      begin
        tx_sh_q <= load_word;
        sdo_q   <= 1'b0;
      end
      else
      begin
        tx_sh_q <= {load_word[WORD_W-2:0], 1'b0};
        sdo_q   <= load_word[WORD_W-1];
      end
    end
    else if (slot_q && fall.bclk)
    begin
      sdo_q   <= tx_sh_q[WORD_W-1];
      tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_buf_q  <= '0;
      tx_full_q <= 1'b0;
    end
    else if (wr_tx)
    begin
      // A write beside a load refills the buffer
      tx_buf_q  <= i_wdata[WORD_W-1:0];
      tx_full_q <= 1'b1;
    end
    else if (take_tx)
      tx_full_q <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_buf_q  <= '0;
      rx_full_q <= 1'b0;
    end
    else if (word_done && (!rx_full_q || rd_rx))
    begin
      rx_buf_q  <= rx_word;
      rx_full_q <= 1'b1;
    end
    else if (rd_rx)
      rx_full_q <= 1'b0;
    // Overflow leaves the held word untouched in both tolerance modes
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      halted_q <= 1'b0;
    else if (!on_q)
      halted_q <= 1'b0;
    else if (ovf && !ctl2_q.ignore_rx_overflow)
      halted_q <= 1'b1;
    else if (udr && !ctl2_q.ignore_tx_underrun)
      halted_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      on_q <= 1'b0;
    else if (wr_ctl1)
      on_q <= i_wdata[CTL1_ON_BIT];
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ctl2_q <= CTL2_RESET;
    else if (wr_ctl2)
    begin
      ctl2_q.rx_sign_extend       <= i_wdata[C2_SIGN_EXT];
      ctl2_q.frame_error_event_en <= i_wdata[C2_FRM_ERR_EN];
      ctl2_q.rx_overflow_event_en <= i_wdata[C2_OVF_EN];
      ctl2_q.tx_underrun_event_en <= i_wdata[C2_UDR_EN];
      ctl2_q.ignore_rx_overflow   <= i_wdata[C2_IGN_OVF];
      ctl2_q.ignore_tx_underrun   <= i_wdata[C2_IGN_UDR];
      if (!on_q)
      begin
        ctl2_q.audio_protocol_en     <= i_wdata[C2_AUD_EN];
        ctl2_q.audio_mono_format     <= i_wdata[C2_MONO];
        ctl2_q.audio_protocol_select <= i_wdata[C2_PROTO_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  sae_evt_t evt;
  assign evt.frame_error_flag = frm_err && ctl2_q.frame_error_event_en;
  assign evt.rx_overflow_flag = ovf && ctl2_q.rx_overflow_event_en;
  assign evt.tx_underrun_flag = udr && ctl2_q.tx_underrun_event_en;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      status_q <= '0;
    else if (wr_stat)
      status_q <= (status_q & ~sae_evt_t'(i_wdata[ST_EVT_LSB +: EVT_W])) | evt;
    else
      status_q <= status_q | evt;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      mask_q <= '0;
    else if (wr_mask)
      mask_q <= sae_evt_t'(i_wdata[ST_EVT_LSB +: EVT_W]);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rx_ext;

  always_comb
  begin
    rx_ext = WORD_ZERO;
    rx_ext[WORD_W-1:0] = rx_buf_q;
    if (ctl2_q.rx_sign_extend && rx_buf_q[WORD_W-1])
      rx_ext = rx_ext | ~(WORD_ZERO | {WORD_W{1'b1}});
  end

  always_comb
  begin
    rd_mux = WORD_ZERO;
    if (i_rd)
    begin
      unique case (i_addr)
        OFS_CTL_ONE: rd_mux[CTL1_ON_BIT] = on_q;
        OFS_CTL_TWO:
        begin
          // Unlisted positions stay zero
          rd_mux[C2_SIGN_EXT]        = ctl2_q.rx_sign_extend;
          rd_mux[C2_FRM_ERR_EN]      = ctl2_q.frame_error_event_en;
          rd_mux[C2_OVF_EN]          = ctl2_q.rx_overflow_event_en;
          rd_mux[C2_UDR_EN]          = ctl2_q.tx_underrun_event_en;
          rd_mux[C2_IGN_OVF]         = ctl2_q.ignore_rx_overflow;
          rd_mux[C2_IGN_UDR]         = ctl2_q.ignore_tx_underrun;
          rd_mux[C2_AUD_EN]          = ctl2_q.audio_protocol_en;
          rd_mux[C2_MONO]            = ctl2_q.audio_mono_format;
          rd_mux[C2_PROTO_LSB +: 2]  = ctl2_q.audio_protocol_select;
        end
        OFS_STATUS:
        begin
          rd_mux[ST_EVT_LSB +: EVT_W] = status_q;
          rd_mux[ST_RX_FULL]          = rx_full_q;
          rd_mux[ST_TX_FULL]          = tx_full_q;
          rd_mux[ST_HALTED]           = halted_q;
        end
        OFS_MASK:    rd_mux[ST_EVT_LSB +: EVT_W] = mask_q;
        OFS_RX_DATA: rd_mux = rx_ext;
        default:     rd_mux = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_q <= WORD_ZERO;
    else
      rdata_q <= rd_mux;
  end

  assign o_rdata   = rdata_q;
  assign o_sdo     = sdo_q;
  assign o_err_irq = irq_q;

endmodule // sae_audio_port

// ===== sim/sae_codec_model.sv
/*
  Codec model: drives bit clock, word select and data in left-justified slots.
  Assumes WORD_W-bit slots; bit clock stands still between slots.
*/
`timescale 1ns/100ps
module sae_codec_model
  import sae_pkg::*;
#(
  parameter int WORD_W = 16,
  parameter int HALF   = 8
) (
  // Port side
  input  wire logic             i_ref_clk,
  input  wire logic             i_sdo,
  // Link pins
  output sae_pkg::sae_link_in_t o_link
);
  initial o_link = '0;

  // A cut below WORD_W leaves the slot in mid-word
  task automatic slot(input logic lvl, input logic [WORD_W-1:0] tx, input int cut,
                      output logic [WORD_W-1:0] rx);
    rx = '0;
    @(posedge i_ref_clk);
    o_link.frame <= lvl;
    o_link.sdi   <= tx[WORD_W-1];
    repeat (HALF) @(posedge i_ref_clk);
    for (int i = 0; i < cut; i++)
    begin
      rx[WORD_W-1-i] = i_sdo;
      o_link.bclk <= 1'b1;
      repeat (HALF) @(posedge i_ref_clk);
      o_link.bclk <= 1'b0;
      // Released line shows the inverse, not a stale bit
      o_link.sdi  <= (i < WORD_W-1) ? tx[WORD_W-2-i] : ~o_link.sdi;
      repeat (HALF) @(posedge i_ref_clk);
    end
  endtask
endmodule // sae_codec_model

// ===== sim/sae_audio_port_monitor.sv
/*
  Checker for the audio port: register shadow and port relations.
  Assumes it is bound to sae_audio_port and sees only its ports.
*/
`timescale 1ns/100ps
module sae_audio_port_monitor
  import sae_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input wire logic                       i_ref_clk,
  input wire logic                       i_rstn,
  input wire logic [sae_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sae_pkg::DATA_W-1:0] i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [sae_pkg::DATA_W-1:0] o_rdata,
  input wire sae_pkg::sae_link_in_t      i_link,
  input wire logic                       o_sdo,
  input wire logic                       o_err_irq
);
  import sae_pkg::*;
  localparam logic [31:0] IMPL = 32'h0000_9F8B;
  localparam logic [31:0] AUD  = 32'h0000_008B;
  logic [31:0] sh_q;
  logic        on_q;
  logic [2:0]  mask_q;
  logic [2:0]  ever_q;
  wire rd_c2 = i_rd && i_addr == OFS_CTL_TWO;
  wire rd_st = i_rd && i_addr == OFS_STATUS;
  wire rd_rx = i_rd && i_addr == OFS_RX_DATA;

  // ----------------------------------------------------------------
  // Shadow
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn) on_q <= 1'b0;
    else if (i_wr && i_addr == OFS_CTL_ONE) on_q <= i_wdata[CTL1_ON_BIT];
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn) sh_q <= '0;
    else if (i_wr && i_addr == OFS_CTL_TWO) sh_q <= on_q ? (sh_q & AUD) | (i_wdata & IMPL & ~AUD) : i_wdata & IMPL;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn) mask_q <= '0;
    else if (i_wr && i_addr == OFS_MASK) mask_q <= i_wdata[2:0];
  // Sticky: an event may outlive a later disable
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn) ever_q <= '0;
    else ever_q <= ever_q | {sh_q[C2_UDR_EN], sh_q[C2_OVF_EN], sh_q[C2_FRM_ERR_EN]};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  ctl2_read_a: assert property ($past(rd_c2) |-> o_rdata == $past(sh_q))
    else $error("control two readback differs");
  ctl2_zero_a: assert property ($past(rd_c2) |-> (o_rdata & ~IMPL) == 32'h0)
    else $error("unimplemented bits set");
  rx_sext_a: assert property ($past(rd_rx && sh_q[C2_SIGN_EXT]) |-> o_rdata[31:WORD_W] == {(32-WORD_W){o_rdata[WORD_W-1]}})
    else $error("receive word not extended");
  rx_plain_a: assert property ($past(rd_rx && !sh_q[C2_SIGN_EXT]) |-> o_rdata[31:WORD_W] == '0)
    else $error("receive word extended");
  evt_gate_a: assert property ($past(rd_st) |-> (o_rdata[2:0] & ~$past(ever_q)) == 3'h0)
    else $error("event set while disabled");
  irq_mask_a: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !o_err_irq)
    else $error("interrupt with all masked");
  irq_fall_a: assert property ($fell(o_err_irq) |-> $past(i_wr, 2))
    else $error("interrupt dropped without write");
  halt_on_a: assert property ($past(rd_st) && o_rdata[ST_HALTED] |-> $past(on_q))
    else $error("halt while port off");

  cover property ($past(rd_st) && o_rdata[ST_HALTED]);
  cover property ($rose(o_err_irq));
  cover property ($past(rd_rx) && o_rdata[31]);
endmodule // sae_audio_port_monitor

bind sae_audio_port sae_audio_port_monitor #(.WORD_W(WORD_W)) i_mon (
  .i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_link(i_link),
  .o_sdo(o_sdo),
  .o_err_irq(o_err_irq)
);

// ===== sim/sae_audio_port_tb.sv
/*
  Testbench for the audio port: register tasks and codec slots.
  Assumes the bound monitor and the left-justified codec model.
*/
`timescale 1ns/100ps
module sae_audio_port_tb;
  import sae_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_rstn    = 1'b0;
  logic [ADDR_W-1:0] i_addr    = '0;
  logic [DATA_W-1:0] i_wdata   = '0;
  logic              i_wr      = 1'b0;
  logic              i_rd      = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  sae_link_in_t      link;
  logic              o_sdo;
  logic              o_err_irq;
  logic [DATA_W-1:0] rv;
  logic [15:0]       sd;
  int                n_mismatch = 0;
  int                cmp_count  = 0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  sae_audio_port #(.WORD_W(16)) i_dut (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_link(link),
    .o_sdo(o_sdo),
    .o_err_irq(o_err_irq)
  );
  sae_codec_model #(.WORD_W(16), .HALF(8)) i_codec (
    .i_ref_clk(i_ref_clk),
    .i_sdo(o_sdo),
    .o_link(link)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(OFS_CTL_TWO);
    chk(rv, WORD_ZERO, "ctl2 reset");
    rd(OFS_STATUS);
    chk(rv, WORD_ZERO, "status reset");
    rd(8'h3C);
    chk(rv, WORD_ZERO, "unmapped");
    $display("test reset done");
    wr(OFS_CTL_TWO, 32'hFFFF_FFFF);
    rd(OFS_CTL_TWO);
    chk(rv, 32'h0000_9F8B, "ctl2 ones");
    wr(OFS_CTL_ONE, 32'h0000_8000);
    wr(OFS_CTL_TWO, WORD_ZERO);
    rd(OFS_CTL_TWO);
    chk(rv, 32'h0000_008B, "audio locked");
    wr(OFS_CTL_ONE, WORD_ZERO);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_CTL_TWO, 32'h0000_0088 | m);
      rd(OFS_CTL_TWO);
      chk(rv, 32'h0000_0088 | m, "protocol code");
    end
    $display("test registers done");
    // Stereo slots: fill, underrun, overflow
    wr(OFS_CTL_TWO, 32'h0000_9F81);
    wr(OFS_MASK, 32'h0000_0007);
    wr(OFS_TX_DATA, 32'h0000_A5C3);
    wr(OFS_CTL_ONE, 32'h0000_8000);
    i_codec.slot(1'b1, 16'h8001, 16, sd);
    chk({16'h0, sd}, 32'h0000_A5C3, "left out");
    rd(OFS_RX_DATA);
    chk(rv, 32'hFFFF_8001, "sign ext");
    i_codec.slot(1'b0, 16'h1234, 16, sd);
    chk({16'h0, sd}, WORD_ZERO, "underrun zeros");
    i_codec.slot(1'b1, 16'h5678, 16, sd);
    rd(OFS_STATUS);
    chk(rv & 32'h0000_0707, 32'h0000_0106, "ovf udr");
    chk({31'h0, o_err_irq}, 32'h1, "irq set");
    rd(OFS_RX_DATA);
    chk(rv, 32'h0000_1234, "old word kept");
    wr(OFS_MASK, WORD_ZERO);
    repeat (2) @(posedge i_ref_clk);
    #1 chk({31'h0, o_err_irq}, WORD_ZERO, "irq masked");
    wr(OFS_STATUS, 32'h0000_0007);
    wr(OFS_MASK, 32'h0000_0007);
    rd(OFS_STATUS);
    chk(rv & 32'h0000_0007, WORD_ZERO, "events cleared");
    $display("test stereo done");
    // Frame edge in mid-word
    i_codec.slot(1'b0, 16'h0000, 5, sd);
    i_codec.slot(1'b1, 16'h0000, 16, sd);
    rd(OFS_STATUS);
    chk(rv & 32'h0000_0001, 32'h0000_0001, "frame error");
    $display("test frame done");
    // Strict underrun halts, events off
    wr(OFS_CTL_ONE, WORD_ZERO);
    wr(OFS_STATUS, 32'h0000_0007);
    wr(OFS_CTL_TWO, 32'h0000_0081);
    wr(OFS_CTL_ONE, 32'h0000_8000);
    i_codec.slot(1'b0, 16'h0000, 16, sd);
    rd(OFS_STATUS);
    chk(rv & 32'h0000_0407, 32'h0000_0400, "halt quiet");
    $display("test halt done");
    // Mono repeats the word in both slots
    wr(OFS_CTL_ONE, WORD_ZERO);
    // Receive word still held: tolerate overflow so both slots run
    wr(OFS_CTL_TWO, 32'h0000_028A);
    wr(OFS_TX_DATA, 32'h0000_3C5A);
    wr(OFS_CTL_ONE, 32'h0000_8000);
    i_codec.slot(1'b1, 16'h0000, 16, sd);
    chk({16'h0, sd}, 32'h0000_3C5A, "mono left");
    i_codec.slot(1'b0, 16'h0000, 16, sd);
    chk({16'h0, sd}, 32'h0000_3C5A, "mono right");
    $display("test mono done");
    // Strict overflow halts: receive word still unread
    wr(OFS_CTL_TWO, 32'h0000_0100);
    i_codec.slot(1'b1, 16'h0000, 16, sd);
    rd(OFS_STATUS);
    chk(rv & 32'h0000_0400, 32'h0000_0400, "overflow halts");
    $display("test overflow halt done");
    report_and_stop();
  end
endmodule // sae_audio_port_tb
